// *** src/tws_pkg.sv ***
// package: constants and carrier types for the terminal write sequencer
`default_nettype none
package tws_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int A_DELAY_NS = 4000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int A_DELAY_CYC = (A_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int B_DELAY_NS = 500;
    localparam int B_DELAY_CYC = (B_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK_RATE_NS = 7000;
    localparam int CLK_RATE_CYC = (CLK_RATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 8;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam int CHAR_W = 6;
    localparam logic [5:0] END_MARKER = 6'h3f;
    localparam logic [1:0] STATUS_WRITE_READY = 2'h3;
    localparam logic [1:0] TYPE_ASCII = 2'h1;
    localparam int BUF_CHARS = 88;
    // ------------------------------------------------------------
    // apb map
    // ------------------------------------------------------------
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_TERM = 12'h004;
    localparam logic [11:0] REG_CTRL = 12'h008;
    localparam logic CTRL_RST = 1'h1;
    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic host_sync_level;
        logic write_inquiry_level;
        logic [5:0] host_data;
    } tws_host_in_t;
    typedef struct packed {
        logic terminal_char_time;
        logic terminal_unit_ready;
        logic final_address_level;
        logic [1:0] status;
        logic [1:0] term_type;
    } tws_term_in_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_LOAD = 6'h02,
        ST_CHECK = 6'h04,
        ST_STATUS = 6'h08,
        ST_REPORT = 6'h10,
        ST_XFER = 6'h20
    } tws_state_t;
endpackage : tws_pkg
`default_nettype wire

// *** src/tws_timer.sv ***
// one-shot delay timer: busy for a fixed count after a trigger
`default_nettype none
module tws_timer #(
    parameter int COUNT = 40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trigger,
    output logic busy
);
    import tws_pkg::*;
    logic [TMR_W-1:0] cnt;
    // ------------------------------------------------------------
    // down counter; retrigger restarts
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (trigger) begin
            cnt <= TMR_W'(COUNT);
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end
    assign busy = (cnt != '0);
endmodule : tws_timer
`default_nettype wire

// *** src/tws_sequencer.sv ***
// terminal write sequencer: host to terminal character relay with apb view
//
// Decided for this implementation: the address map and the APB interface to the registers.
`default_nettype none
// What this block does
// - end on end marker or final address
// - sync from idle loads S register
// - inquiry at Q2/3 goes to P6 Q0
// - B clock tests ready, clears A-occupied
// - A clock picks Q1 or Q3
// - capture status into R, type T
// - status 3 sets write ready flag
// - report: S to B, ready, char time
// - char time gated, settles half microsecond
// - second B clock clears B-occupied
// - load A, translate into B, request
// - third char waits for terminal accept
// - terminal accept moves next char
// - A unoccupied loads next host char
// - end waits terminal not write ready
// - A delay timer four microseconds
module tws_sequencer #(
    parameter int A_CYC = tws_pkg::A_DELAY_CYC,
    parameter int B_CYC = tws_pkg::B_DELAY_CYC,
    parameter int GAP_CYC = tws_pkg::CLK_RATE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tws_pkg::tws_host_in_t host_in,
    output logic host_char_timing,
    output logic host_write_ready_level,
    input wire tws_pkg::tws_term_in_t term_in,
    output logic terminal_char_strobe,
    output logic [5:0] term_data
);
    import tws_pkg::*;
    tws_state_t state;
    logic [1:0] q;
    logic [5:0] s_reg, a_reg, b_reg;
    logic [1:0] r_reg, t_reg;
    logic a_occupied_flag, b_occupied_flag, strobe_hold_flag, write_ready_flag;
    logic ending, soft_rst, a_trig, b_trig, a_busy, b_busy;
    logic [TMR_W-1:0] gap;
    logic gap_ok, a_clk, b_clk;
    logic [6:0] char_cnt;
    logic sync_q;

    // ------------------------------------------------------------
    // delay timers
    // ------------------------------------------------------------
    tws_timer #(.COUNT(A_CYC)) u_a_delay_timer (
        .pclk(pclk), .presetn(presetn), .trigger(a_trig), .busy(a_busy)
    );
    tws_timer #(.COUNT(B_CYC)) u_b_delay_timer (
        .pclk(pclk), .presetn(presetn), .trigger(b_trig), .busy(b_busy)
    );

    // minimum spacing between clock pulses (the 7 us clock rate)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= '0;
        end else if (a_clk || b_clk) begin
            gap <= TMR_W'(GAP_CYC);
        end else if (gap != '0) begin
            gap <= gap - 1'b1;
        end
    end
    assign gap_ok = (gap == '0);

    // translator: processor code to ascii, bit 5 toggle (xor 6'h20) stand-in for the table
    function automatic logic [5:0] xlate(input logic [5:0] c, input logic [1:0] ty);
        xlate = (ty == TYPE_ASCII) ? (c ^ 6'h20) : c;
    endfunction : xlate

    // ------------------------------------------------------------
    // A and B clock enables
    // ------------------------------------------------------------
    always_comb begin
        a_clk = 1'b0;
        b_clk = 1'b0;
        case (state)
            ST_IDLE: a_clk = host_in.host_sync_level;
            ST_LOAD: a_clk = host_in.host_sync_level;
            ST_CHECK: begin
                b_clk = a_occupied_flag && !a_busy;
                a_clk = !a_occupied_flag && gap_ok;
            end
            ST_STATUS: a_clk = term_in.terminal_char_time;
            ST_REPORT: begin
                b_clk = (a_occupied_flag && !a_busy) ||
                        (!a_occupied_flag && b_occupied_flag && gap_ok);
                a_clk = !a_occupied_flag && !b_occupied_flag && !host_in.host_sync_level;
            end
            ST_XFER: begin
                if (q == 2'h0) begin
                    a_clk = !a_occupied_flag && host_in.write_inquiry_level && !ending
                            && gap_ok;
                    b_clk = a_occupied_flag && !a_busy && !b_occupied_flag;
                end else begin
                    a_clk = !term_in.status[0] || !write_ready_flag;
                end
            end
            default: begin
                a_clk = 1'b0;
                b_clk = 1'b0;
            end
        endcase
    end
    // every A clock past idle restarts the A delay, so the check B clock waits too
    assign a_trig = a_clk && (state != ST_IDLE);

    // ------------------------------------------------------------
    // sequencer state and q count
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            q <= 2'h0;
        end else if (soft_rst) begin
            state <= ST_IDLE;
            q <= 2'h0;
        end else if (a_clk) begin
            case (state)
                ST_IDLE: begin
                    state <= ST_LOAD;
                    q <= 2'h2;
                end
                ST_LOAD: if (host_in.write_inquiry_level) begin
                    state <= ST_CHECK;
                    q <= 2'h0;
                end
                ST_CHECK: begin
                    state <= b_occupied_flag ? ST_STATUS : ST_REPORT;
                    q <= b_occupied_flag ? 2'h1 : 2'h3;
                end
                ST_STATUS: begin
                    state <= ST_REPORT;
                    q <= 2'h3;
                end
                ST_REPORT: begin
                    state <= write_ready_flag ? ST_XFER : ST_IDLE;
                    q <= 2'h0;
                end
                ST_XFER: if (q != 2'h0) begin
                    state <= ST_IDLE;
                    q <= 2'h0;
                end
                default: begin
                    state <= ST_IDLE;
                    q <= 2'h0;
                end
            endcase
        end else if (state == ST_XFER && q == 2'h0 && ending && !b_occupied_flag
                     && !a_occupied_flag) begin
            q <= 2'h3;
        end
    end

    // end detection: end marker sent or terminal buffer full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ending <= 1'b0;
            char_cnt <= '0;
        end else if (state != ST_XFER) begin
            ending <= 1'b0;
            char_cnt <= '0;
        end else if (b_clk) begin
            char_cnt <= char_cnt + 1'b1;
            if (a_reg == END_MARKER || term_in.final_address_level ||
                char_cnt == 7'(BUF_CHARS - 1)) begin
                ending <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // occupancy and strobe hold flags
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_occupied_flag <= 1'b0;
            b_occupied_flag <= 1'b0;
            strobe_hold_flag <= 1'b0;
        end else if (soft_rst || state == ST_IDLE || state == ST_LOAD) begin
            a_occupied_flag <= state == ST_LOAD && a_clk && host_in.write_inquiry_level;
            b_occupied_flag <= 1'b0;
            strobe_hold_flag <= 1'b0;
        end else begin
            case (state)
                ST_CHECK: if (b_clk) begin
                    b_occupied_flag <= term_in.terminal_unit_ready;
                    a_occupied_flag <= 1'b0;
                end else if (a_clk && !b_occupied_flag) begin
                    a_occupied_flag <= 1'b1;
                end
                ST_STATUS: if (a_clk) begin
                    a_occupied_flag <= 1'b1;
                    b_occupied_flag <= 1'b0;
                end
                ST_REPORT: if (b_clk && a_occupied_flag) begin
                    a_occupied_flag <= 1'b0;
                    b_occupied_flag <= 1'b1;
                end else if (b_clk) begin
                    b_occupied_flag <= 1'b0;
                end
                ST_XFER: begin
                    if (a_clk && q == 2'h0) begin
                        a_occupied_flag <= 1'b1;
                        strobe_hold_flag <= !b_occupied_flag && !strobe_hold_flag;
                    end else if (b_clk) begin
                        a_occupied_flag <= 1'b0;
                        b_occupied_flag <= 1'b1;
                        strobe_hold_flag <= 1'b0;
                    end else if (b_occupied_flag && !strobe_hold_flag &&
                                 term_in.terminal_char_time) begin
                        b_occupied_flag <= 1'b0;
                    end
                end
                default: begin
                    a_occupied_flag <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            a_reg <= '0;
            b_reg <= '0;
        end else begin
            if (state == ST_LOAD && a_clk) begin
                s_reg <= host_in.host_data;
            end
            if (state == ST_XFER && q == 2'h0 && a_clk) begin
                a_reg <= host_in.host_data;
            end
            if (state == ST_REPORT && b_clk && a_occupied_flag) begin
                b_reg <= s_reg;
            end else if (state == ST_XFER && b_clk) begin
                b_reg <= xlate(a_reg, t_reg);
            end
        end
    end

    // status capture, held until idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            t_reg <= '0;
            write_ready_flag <= 1'b0;
        end else if (state == ST_IDLE) begin
            r_reg <= '0;
            t_reg <= '0;
            write_ready_flag <= 1'b0;
        end else if (state == ST_STATUS && a_clk) begin
            r_reg <= term_in.status;
            t_reg <= term_in.term_type;
            write_ready_flag <= (term_in.status == STATUS_WRITE_READY);
        end
    end

    // host outputs: char time after A-occupied drops outside transfer, settle time from B timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_write_ready_level <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            sync_q <= b_busy;
            if (state == ST_IDLE) begin
                host_write_ready_level <= 1'b0;
            end else if (state == ST_REPORT && b_clk && a_occupied_flag) begin
                host_write_ready_level <= write_ready_flag;
            end
        end
    end
    assign b_trig = (state == ST_REPORT && b_clk && a_occupied_flag) ||
                    (state == ST_XFER && a_clk && q == 2'h0 && !ending);
    // in transfer the request follows each A load, while A still holds the new character
    assign host_char_timing = sync_q && !b_busy
                              && (!a_occupied_flag || state == ST_XFER);
    assign terminal_char_strobe = (state == ST_XFER) && b_occupied_flag
                                  && !strobe_hold_flag;
    assign term_data = b_reg;

    // ------------------------------------------------------------
    // apb slave: zero wait states
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == REG_STATUS || paddr == REG_TERM
                                         || paddr == REG_CTRL);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= psel && penable && pwrite && paddr == REG_CTRL && pwdata[0] == CTRL_RST;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                REG_STATUS: prdata <= {18'h0, q, state, a_occupied_flag, b_occupied_flag,
                                       strobe_hold_flag, write_ready_flag, ending, 1'b0};
                REG_TERM: prdata <= {8'h0, r_reg, t_reg, s_reg, a_reg, b_reg};
                default: prdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence load_step;
        state == ST_LOAD && a_clk && host_in.write_inquiry_level;
    endsequence
    idle_to_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_IDLE && a_clk && !soft_rst |=> state == ST_LOAD && q == 2'h2)
        else $error("sync did not move idle to load");
    load_to_check_a: assert property (@(posedge pclk) disable iff (!presetn)
        load_step and !soft_rst |=> state == ST_CHECK && q == 2'h0)
        else $error("inquiry did not reach check");
    check_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_CHECK && b_clk && !soft_rst |=> !a_occupied_flag)
        else $error("a occupied not cleared at check");
    status_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_XFER && $past(state) == ST_XFER |-> $stable(write_ready_flag)
        && $stable(t_reg))
        else $error("status changed during transfer");
    ready_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_STATUS && a_clk && !soft_rst |=>
        write_ready_flag == (r_reg == STATUS_WRITE_READY))
        else $error("write ready flag mismatch");
    a_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_XFER && $rose(a_occupied_flag) |-> !b_clk [*8])
        else $error("b clock before a delay");
    strobe_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        terminal_char_strobe |-> $stable(term_data) || $past(b_clk))
        else $error("data moved under strobe");
    end_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_XFER && q == 2'h3 && term_in.status[0] && write_ready_flag
        |=> state == ST_XFER || soft_rst)
        else $error("left transfer while terminal write ready");
endmodule : tws_sequencer
`default_nettype wire

// *** verification/tws_term_model.sv ***
// terminal-side partner model: stores translated characters, reports status
`default_nettype none
module tws_term_model #(
    parameter int FINAL_AT = 88,
    parameter int HOLD = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic terminal_char_strobe,
    input wire logic [5:0] term_data,
    input wire logic unit_ready,
    input wire logic arm,
    output var tws_pkg::tws_term_in_t term_in,
    output var int n_got
);
    import tws_pkg::*;
    logic [5:0] got [0:255];
    logic strobe_q;
    logic done;
    int cnt;
    int hold;
    // ------------------------------------------------------------
    // character store
    // ------------------------------------------------------------
    // a store only on a fresh strobe, so a level left high is not taken twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_q <= 1'b0;
            done <= 1'b0;
            cnt <= 0;
            hold <= 0;
            n_got <= 0;
        end else begin
            strobe_q <= terminal_char_strobe;
            if (hold > 0) begin
                hold <= hold - 1;
            end
            if (!arm) begin
                done <= 1'b0;
                cnt <= 0;
            end else if (terminal_char_strobe && !strobe_q && hold == 0 && !done) begin
                got[n_got] <= term_data;
                n_got <= n_got + 1;
                cnt <= cnt + 1;
                hold <= HOLD;
                if (cnt + 1 == FINAL_AT || term_data == END_MARKER
                        || term_data == (END_MARKER ^ 6'h20)) begin
                    done <= 1'b1;
                end
            end
        end
    end
    // status levels; write ready drops once the last store has settled
    assign term_in.terminal_char_time = (hold == 0) && !done;
    assign term_in.terminal_unit_ready = unit_ready;
    assign term_in.final_address_level = arm && (cnt == FINAL_AT - 1);
    assign term_in.status = (arm && !(done && hold == 0)) ? STATUS_WRITE_READY : 2'h0;
    assign term_in.term_type = TYPE_ASCII;
endmodule : tws_term_model
`default_nettype wire

// *** verification/terminal_write_sequencer_tb_top.sv ***
// testbench: sequencer driven from host, terminal model and apb
`default_nettype none
module terminal_write_sequencer_tb_top;
    import tws_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    tws_host_in_t host_in;
    tws_term_in_t term_in;
    logic host_char_timing, host_write_ready_level, terminal_char_strobe;
    logic [5:0] term_data;
    logic unit_ready, arm;
    int n_got, n_fail, n_compared;
    // ------------------------------------------------------------
    // clock and instances
    // ------------------------------------------------------------
    always #50 pclk = ~pclk;
    tws_sequencer #(.A_CYC(8), .B_CYC(2), .GAP_CYC(6)) i_tws_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_in(host_in), .host_char_timing(host_char_timing),
        .host_write_ready_level(host_write_ready_level), .term_in(term_in),
        .terminal_char_strobe(terminal_char_strobe), .term_data(term_data));
    tws_term_model #(.FINAL_AT(BUF_CHARS), .HOLD(5)) i_tws_term_model (
        .pclk(pclk), .presetn(presetn), .terminal_char_strobe(terminal_char_strobe),
        .term_data(term_data), .unit_ready(unit_ready), .arm(arm), .term_in(term_in),
        .n_got(n_got));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic summarize;
        if (n_fail == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    // bounded poll: which 0 watches character timing, 1 watches write ready
    task automatic wait_for(input bit which, input logic v);
        int k;
        k = 0;
        while ((which ? host_write_ready_level : host_char_timing) !== v) begin
            @(posedge pclk);
            k++;
            if (k > 3000) begin
                chk("wait bound", 0, 1);
                summarize();
            end
        end
    endtask : wait_for
    // one apb transfer; an edge passes first so no signal is set twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        chk("pready", pready, 1);
        if (pready !== 1'b1) begin
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_apb_map;
        logic [31:0] rd;
        logic err;
        apb(0, REG_STATUS, 0, rd, err);
        chk("status err", err, 0);
        chk("status idle", rd, 32'h0000_0040); // idle one-hot sits at bits 11:6
        apb(0, REG_TERM, 0, rd, err);
        chk("term err", err, 0);
        chk("term idle", rd, 32'h0000_0000);
        apb(0, 12'h0fc, 0, rd, err);
        chk("unmapped err", err, 1);
        chk("unmapped data", rd, 0);
        apb(1, 12'h0f0, 32'h0000_00ff, rd, err);
        chk("unmapped wr err", err, 1);
    endtask : s_apb_map
    // host side of one write; characters stay clear of the end marker
    task automatic run_write(input int n, input bit mark, input bit ready, input bit wr_ok);
        logic [5:0] c;
        int base;
        @(posedge pclk);
        base = n_got;
        unit_ready <= ready;
        arm <= wr_ok;
        host_in <= {1'b1, 1'b1, 6'h05};
        wait_for(0, 1);
        chk("write ready", host_write_ready_level, wr_ok);
        @(posedge pclk);
        if (!wr_ok) begin
            host_in <= '0;
            repeat (30) @(posedge pclk);
            chk("strobe idle", terminal_char_strobe, 0);
            chk("ready idle", host_write_ready_level, 0);
            arm <= 1'b0;
            return;
        end
        for (int i = 0; i < n + mark; i++) begin
            c = (i == n) ? END_MARKER : 6'(i % 30 + 1);
            host_in <= {1'b0, 1'b1, c};
            if (i == n / 2) begin
                chk("ready held", host_write_ready_level, 1);
            end
            if (i < n + mark - 1) begin
                wait_for(0, 0);
                wait_for(0, 1);
            end
            @(posedge pclk);
        end
        wait_for(1, 0);
        host_in <= '0;
        arm <= 1'b0;
        chk("stored count", n_got - base, n + mark);
        for (int k = 0; k < n; k++) begin
            chk("term char", i_tws_term_model.got[base + k], 6'(k % 30 + 1) ^ 6'h20);
        end
        @(posedge pclk);
    endtask : run_write
    task automatic s_soft_return;
        logic [31:0] rd;
        logic err;
        @(posedge pclk);
        unit_ready <= 1'b1;
        arm <= 1'b1;
        host_in <= {1'b1, 1'b1, 6'h05};
        wait_for(0, 1);
        chk("ready before abort", host_write_ready_level, 1);
        apb(1, REG_CTRL, {31'h0, CTRL_RST}, rd, err);
        chk("ctrl err", err, 0);
        repeat (3) @(posedge pclk);
        chk("ready after abort", host_write_ready_level, 0);
        host_in <= '0;
        arm <= 1'b0;
    endtask : s_soft_return
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        host_in = '0;
        unit_ready = 1'b0;
        arm = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        s_apb_map();
        run_write(0, 0, 0, 0);
        run_write(0, 0, 1, 0);
        run_write(5, 1, 1, 1);
        run_write(BUF_CHARS, 0, 1, 1);
        s_soft_return();
        summarize();
    end
endmodule : terminal_write_sequencer_tb_top
`default_nettype wire
